//--- rtl/bed_defs.svh
// constants for the banked data-space and nvm access block
`ifndef BED_DEFS_SVH
`define BED_DEFS_SVH
`define BED_ADDR_BANK_SEL 8'hcb
`define BED_ADDR_NVM_CTL 8'hdf
`define BED_PAGED_LAST 8'h3f
`define BED_CTL_RESET 8'h00
`define BED_BIT_PROG_EN 0
`define BED_BIT_BUSY 1
`define BED_BIT_ROW_MODE 2
`define BED_BIT_ROW_START 3
`define BED_BIT_STANDBY 6
`define BED_SEL_NVM0 0
`define BED_SEL_NVM1 1
`define BED_SEL_RAM1 3
`define BED_SEL_RAM2 4
`define BED_SEL_LCD1 5
`define BED_SEL_LCD2 6
`define BED_PROG_TIME_US 5000
`define BED_CLK_MHZ 10
`define BED_PROG_CYCLES (`BED_PROG_TIME_US * `BED_CLK_MHZ)
`define BED_ROW_BYTES 8
`endif

//--- rtl/bed_pkg.sv
// types shared by the banked nvm access modules
package bed_pkg;
	typedef enum logic [1:0] {
		BED_IDLE,
		BED_BYTE_PROG,
		BED_ROW_PROG
	} bed_state_t;
	typedef logic [7:0] bed_byte_t;
endpackage

//--- rtl/bed_row_if.sv
// carrier between the controller and the row latch module
interface bed_row_if;
	logic clear;
	logic load;
	logic [2:0] col;
	logic [7:0] wdata;
	logic [7:0] used;
	logic [63:0] bytes;
	modport ctl (output clear, output load, output col, output wdata, input used, input bytes);
	modport lat (input clear, input load, input col, input wdata, output used, output bytes);
endinterface

//--- rtl/bed_row_latch.sv
// eight volatile row latches with per-byte written marks
module bed_row_latch #(
	parameter int ROW_BYTES = 8
) (
	input wire logic sys_clk,
	input wire logic srst,
	bed_row_if.lat row
);
	initial begin
		if (ROW_BYTES != 8) $error("row latch supports eight bytes only");
	end
	// marks clear on entry to row mode, so unwritten bytes stay untouched
	always_ff @(posedge sys_clk) begin
		if (srst || row.clear) begin
			row.used <= 8'h00;
		end else if (row.load) begin
			row.used[row.col] <= 1'b1;
		end
	end
	// data latches
	always_ff @(posedge sys_clk) begin
		if (srst || row.clear) begin
			row.bytes <= 64'h0;
		end else if (row.load) begin
			row.bytes[row.col*8 +: 8] <= row.wdata;
		end
	end
endmodule

//--- rtl/bed_prog_timer.sv
// programming cycle timer: pulse done after a fixed number of cycles
module bed_prog_timer #(
	parameter int CYCLES = 50000
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic start,
	output logic running,
	output logic done
);
	logic [31:0] cnt_q;
	initial begin
		if (CYCLES < 1) $error("programming time must be at least one cycle");
	end
	// counts down from start; done marks the last running cycle, so a caller
	// that leaves its busy state on done is busy for exactly CYCLES cycles
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_q <= 32'h0;
			running <= 1'b0;
		end else begin
			if (start && !running) begin
				cnt_q <= 32'(CYCLES - 1);
				running <= 1'b1;
			end else if (running) begin
				if (cnt_q == 32'h0) begin
					running <= 1'b0;
				end else begin
					cnt_q <= cnt_q - 32'h1;
				end
			end
		end
	end
	assign done = running && (cnt_q == 32'h0);
endmodule

//--- rtl/bed_nvm_access.sv
// bank selection and data nvm access control on the core's data bus
`include "bed_defs.svh"
module bed_nvm_access #(
	parameter int PROG_CYCLES = `BED_PROG_CYCLES
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic bus_bit_op,
	output logic [7:0] bus_rdata,
	output logic bus_rdata_valid,
	output logic [6:0] page_sel,
	output logic page_access,
	output logic nvm_standby,
	output logic nvm_busy_flag,
	output logic row_mode_out,
	output logic row_error
);
	initial begin
		if (PROG_CYCLES < 1) $error("programming time must be at least one cycle");
	end

	// nvm array: two pages of 64 bytes, delivered in the erased state ff
	logic [7:0] nvm_mem [0:127] = '{default: 8'hff};

	logic [7:0] bank_q;
	logic bank_ok_q;
	logic prog_en_q;
	logic row_mode_q;
	logic row_start_q;
	logic [6:0] row_addr_q;
	logic row_locked_q;
	logic [6:0] byte_addr_q;
	logic [7:0] byte_data_q;
	bed_pkg::bed_state_t state_q;
	logic tmr_start;
	logic tmr_running;
	logic tmr_done;
	logic in_page;
	logic nvm_sel;
	logic [6:0] nvm_addr;
	logic ctl_wr;
	logic bank_wr;
	logic nvm_wr;
	logic nvm_rd;
	logic busy;

	bed_row_if row ();

	bed_row_latch #(.ROW_BYTES(`BED_ROW_BYTES)) u_row (
		.sys_clk(sys_clk),
		.srst(srst),
		.row(row)
	);

	bed_prog_timer #(.CYCLES(PROG_CYCLES)) u_tmr (
		.sys_clk(sys_clk),
		.srst(srst),
		.start(tmr_start),
		.running(tmr_running),
		.done(tmr_done)
	);

	// decode; the core addresses the page as if it were bank 0
	assign busy = (state_q != bed_pkg::BED_IDLE);
	assign in_page = (bus_addr <= `BED_PAGED_LAST);
	assign nvm_sel = bank_ok_q && (bank_q[`BED_SEL_NVM0] ^ bank_q[`BED_SEL_NVM1]);
	assign nvm_addr = {bank_q[`BED_SEL_NVM1], bus_addr[5:0]};
	assign bank_wr = bus_wr && !bus_bit_op && (bus_addr == `BED_ADDR_BANK_SEL);
	assign ctl_wr = bus_wr && (bus_addr == `BED_ADDR_NVM_CTL) && !busy;
	assign nvm_wr = bus_wr && in_page && nvm_sel && !nvm_standby && !busy;
	assign nvm_rd = bus_rd && in_page && nvm_sel && !nvm_standby && !busy;
	assign row.clear = ctl_wr && bus_wdata[`BED_BIT_ROW_MODE] && !row_mode_q;
	assign row.load = nvm_wr && prog_en_q && row_mode_q && !row_start_q;
	assign row.col = bus_addr[2:0];
	assign row.wdata = bus_wdata;

	// bank register: uninitialised content, only a valid flag is reset
	always_ff @(posedge sys_clk) begin
		if (bank_wr) begin
			bank_q <= bus_wdata;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bank_ok_q <= 1'b0;
		end else if (bank_wr) begin
			bank_ok_q <= 1'b1;
		end
	end

	// control register; bits 7,5,4 are not stored so they stay zero
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prog_en_q <= 1'b0;
			nvm_standby <= 1'b0;
			row_mode_q <= 1'b0;
			row_start_q <= 1'b0;
		end else if (ctl_wr) begin
			prog_en_q <= bus_wdata[`BED_BIT_PROG_EN];
			nvm_standby <= bus_wdata[`BED_BIT_STANDBY];
			row_mode_q <= bus_wdata[`BED_BIT_ROW_MODE];
			// start only sticks with enable and row mode already set
			row_start_q <= bus_wdata[`BED_BIT_ROW_START] && prog_en_q && row_mode_q;
		end else if (tmr_done && state_q == bed_pkg::BED_ROW_PROG) begin
			row_mode_q <= 1'b0;
			row_start_q <= 1'b0;
		end
	end

	// row address lock: first write in row mode fixes a6..a3
	always_ff @(posedge sys_clk) begin
		if (srst || !row_mode_q) begin
			row_locked_q <= 1'b0;
			row_addr_q <= 7'h00;
		end else if (row.load && !row_locked_q) begin
			row_locked_q <= 1'b1;
			row_addr_q <= nvm_addr;
		end
	end

	// sticky error for writes or reads outside the locked row
	always_ff @(posedge sys_clk) begin
		if (srst || row.clear) begin
			row_error <= 1'b0;
		end else if ((nvm_wr || nvm_rd) && row_mode_q && row_locked_q
			&& nvm_addr[6:3] != row_addr_q[6:3]) begin
			row_error <= 1'b1;
		end
	end

	// programming sequencer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= bed_pkg::BED_IDLE;
			byte_addr_q <= 7'h00;
			byte_data_q <= 8'h00;
		end else begin
			unique case (state_q)
				bed_pkg::BED_IDLE: begin
					if (nvm_wr && prog_en_q && !row_mode_q) begin
						state_q <= bed_pkg::BED_BYTE_PROG;
						byte_addr_q <= nvm_addr;
						byte_data_q <= bus_wdata;
					end else if (row_start_q) begin
						state_q <= bed_pkg::BED_ROW_PROG;
					end
				end
				bed_pkg::BED_BYTE_PROG,
				bed_pkg::BED_ROW_PROG: begin
					if (tmr_done) state_q <= bed_pkg::BED_IDLE;
				end
			endcase
		end
	end
	assign tmr_start = (state_q != bed_pkg::BED_IDLE) && !tmr_running && !tmr_done;

	// cells change only at the end of the cycle; unmarked row bytes kept
	always_ff @(posedge sys_clk) begin
		if (tmr_done && state_q == bed_pkg::BED_BYTE_PROG) begin
			nvm_mem[byte_addr_q] <= byte_data_q;
		end else if (tmr_done && state_q == bed_pkg::BED_ROW_PROG) begin
			for (int i = 0; i < 8; i++) begin
				if (row.used[i]) begin
					nvm_mem[{row_addr_q[6:3], 3'(i)}] <= row.bytes[i*8 +: 8];
				end
			end
		end
	end

	// busy flag rises one cycle after the sequencer leaves idle and falls as it returns
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			nvm_busy_flag <= 1'b0;
		end else begin
			nvm_busy_flag <= (state_q == bed_pkg::BED_IDLE) ? (tmr_start || 1'b0) :
				!tmr_done;
		end
	end

	// read path: one cycle, same as ordinary data ram
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bus_rdata <= 8'h00;
			bus_rdata_valid <= 1'b0;
		end else begin
			bus_rdata_valid <= 1'b0;
			if (bus_rd && bus_addr == `BED_ADDR_NVM_CTL) begin
				bus_rdata <= {6'h00, busy, 1'b0};
				bus_rdata_valid <= 1'b1;
			end else if (nvm_rd) begin
				bus_rdata <= nvm_mem[nvm_addr];
				bus_rdata_valid <= 1'b1;
			end
		end
	end

	// page strobes for the nvm, ram and lcd banks, sent outside this block
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			page_sel <= 7'h00;
			page_access <= 1'b0;
			row_mode_out <= 1'b0;
		end else begin
			page_sel <= bank_ok_q ? bank_q[6:0] & 7'h7b : 7'h00;
			page_access <= (bus_rd || bus_wr) && in_page && bank_ok_q;
			row_mode_out <= row_mode_q;
		end
	end

	// helper: length of the current busy stretch, for the exact-duration check
	logic [31:0] busy_len_q;
	always_ff @(posedge sys_clk) begin
		if (srst || !nvm_busy_flag) begin
			busy_len_q <= 32'h0;
		end else begin
			busy_len_q <= busy_len_q + 32'h1;
		end
	end

	// control register reset and read-back
	a_ctl_reset: assert property (@(posedge sys_clk)
		srst |=> !prog_en_q && !row_mode_q && !nvm_standby)
		else $error("control not cleared by reset");
	a_idle_read: assert property (@(posedge sys_clk) disable iff (srst)
		!busy && bus_rd && bus_addr == `BED_ADDR_NVM_CTL |=> bus_rdata == 8'h00)
		else $error("control read shows stray bits");
	a_busy_read: assert property (@(posedge sys_clk) disable iff (srst)
		busy && bus_rd && bus_addr == `BED_ADDR_NVM_CTL |=> bus_rdata == 8'h02)
		else $error("busy read wrong");
	a_busy_blocks: assert property (@(posedge sys_clk) disable iff (srst)
		busy && bus_wr && bus_addr == `BED_ADDR_NVM_CTL |=> $stable(prog_en_q))
		else $error("control written while busy");

	// bank register: whole-byte writes only, otherwise left alone
	a_bank_bitop: assert property (@(posedge sys_clk) disable iff (srst)
		bank_ok_q && bus_wr && bus_bit_op && bus_addr == `BED_ADDR_BANK_SEL |=> $stable(bank_q))
		else $error("bank changed by bit operation");
	a_bank_hold: assert property (@(posedge sys_clk) disable iff (srst)
		bank_ok_q && !bank_wr |=> $stable(bank_q))
		else $error("bank changed without a write");
	a_no_bank: assert property (@(posedge sys_clk) disable iff (srst)
		!bank_ok_q && state_q == bed_pkg::BED_IDLE && !row_start_q && bus_wr && in_page
		|=> state_q == bed_pkg::BED_IDLE) else $error("programming with no bank");
	a_page_access: assert property (@(posedge sys_clk) disable iff (srst)
		bank_ok_q && bus_rd && in_page |=> page_access)
		else $error("paged access not flagged");

	// standby and busy refuse array accesses
	a_standby_rd: assert property (@(posedge sys_clk) disable iff (srst)
		nvm_standby && bus_rd && bus_addr != `BED_ADDR_NVM_CTL |=> !bus_rdata_valid)
		else $error("read while in standby");
	a_standby_wr: assert property (@(posedge sys_clk) disable iff (srst)
		nvm_standby && state_q == bed_pkg::BED_IDLE && !row_start_q && bus_wr && in_page
		|=> state_q == bed_pkg::BED_IDLE) else $error("programming in standby");
	a_busy_abort: assert property (@(posedge sys_clk) disable iff (srst)
		busy && bus_rd && bus_addr != `BED_ADDR_NVM_CTL |=> !bus_rdata_valid)
		else $error("read answered while busy");
	a_read_time: assert property (@(posedge sys_clk) disable iff (srst)
		nvm_rd |=> bus_rdata_valid)
		else $error("nvm read not answered in one cycle");
	a_rdata_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!bus_rd |=> $stable(bus_rdata))
		else $error("read data changed without a read");

	// byte mode and row latch handling
	a_no_en_prog: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == bed_pkg::BED_IDLE && !prog_en_q && !row_start_q
		|=> state_q == bed_pkg::BED_IDLE) else $error("programming without enable");
	a_byte_start: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == bed_pkg::BED_IDLE && nvm_wr && prog_en_q && !row_mode_q
		|=> state_q == bed_pkg::BED_BYTE_PROG) else $error("byte write not programmed");
	a_row_no_prog: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == bed_pkg::BED_IDLE && row_mode_q |=> state_q != bed_pkg::BED_BYTE_PROG)
		else $error("row mode write programmed a cell");
	a_latch_clear: assert property (@(posedge sys_clk) disable iff (srst)
		row.clear |=> row.used == 8'h00)
		else $error("row latches not cleared");
	a_latch_mark: assert property (@(posedge sys_clk) disable iff (srst)
		row.load |=> row.used[$past(row.col)])
		else $error("loaded byte not marked");
	a_used_keep: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == bed_pkg::BED_ROW_PROG |=> $stable(row.used))
		else $error("row marks changed while programming");

	// row address lock and its error flag
	a_addr_lock: assert property (@(posedge sys_clk) disable iff (srst)
		row_locked_q |=> !row_locked_q || $stable(row_addr_q))
		else $error("locked row address moved");
	a_row_error: assert property (@(posedge sys_clk) disable iff (srst)
		row.load && row_locked_q && nvm_addr[6:3] != row_addr_q[6:3] |=> row_error)
		else $error("foreign row write not flagged");
	a_err_clear: assert property (@(posedge sys_clk) disable iff (srst)
		row.clear |=> !row_error)
		else $error("row error not cleared on row mode entry");

	// row start, end and abandon
	a_start_gate: assert property (@(posedge sys_clk) disable iff (srst)
		ctl_wr && !(prog_en_q && row_mode_q) |=> !row_start_q)
		else $error("start bit accepted illegally");
	a_row_end: assert property (@(posedge sys_clk) disable iff (srst)
		tmr_done && state_q == bed_pkg::BED_ROW_PROG |=> !row_mode_q && !row_start_q)
		else $error("row bits not cleared");
	a_row_abandon: assert property (@(posedge sys_clk) disable iff (srst)
		ctl_wr && row_mode_q && !row_start_q && !bus_wdata[`BED_BIT_ROW_MODE]
		&& !bus_wdata[`BED_BIT_ROW_START] |=> !row_start_q ##1 state_q != bed_pkg::BED_ROW_PROG)
		else $error("abandoned row programmed");

	// programming time: busy lasts exactly the parameter, never longer
	a_busy_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!$past(srst) && $fell(nvm_busy_flag) |-> busy_len_q == 32'(PROG_CYCLES))
		else $error("busy length wrong");
	a_busy_bound: assert property (@(posedge sys_clk) disable iff (srst)
		nvm_busy_flag |-> busy_len_q < 32'(PROG_CYCLES))
		else $error("busy held too long");
	a_timer_idle: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == bed_pkg::BED_IDLE |-> !tmr_running)
		else $error("timer running while idle");

	c_byte_prog: cover property (@(posedge sys_clk) state_q == bed_pkg::BED_BYTE_PROG);
	c_row_prog: cover property (@(posedge sys_clk) state_q == bed_pkg::BED_ROW_PROG);
	c_row_abandon: cover property (@(posedge sys_clk) $fell(row_mode_q) && !busy);
	c_busy_read: cover property (@(posedge sys_clk) busy && bus_rd
		&& bus_addr == `BED_ADDR_NVM_CTL);
	c_row_error: cover property (@(posedge sys_clk) $rose(row_error));
endmodule

//--- verification/bed_core_model.sv
// processor core model driving the data-space bus of the nvm block
module bed_core_model (
	input wire logic sys_clk,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_rdata_valid,
	output logic [7:0] bus_addr,
	output logic [7:0] bus_wdata,
	output logic bus_wr,
	output logic bus_rd,
	output logic bus_bit_op
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus from time zero, so nothing is taken during reset
	initial begin
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_bit_op = 1'b0;
	end
	// one-cycle write strobe, launched just after an edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bop);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_bit_op <= bop;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		bus_bit_op <= 1'b0;
		bus_wdata <= ~d; // released data must not linger
	endtask
	// read strobe; the answer is looked for in the two cycles after it
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		v = 1'b0;
		d = 8'h00;
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		repeat (2) begin
			#1;
			if (bus_rdata_valid === 1'b1) begin
				v = 1'b1;
				d = bus_rdata;
			end
			@(posedge sys_clk);
		end
	endtask
endmodule

//--- verification/test_banked_eeprom_data_access.sv
// self-checking bench for the banked nvm access block
module test_banked_eeprom_data_access;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PROG = 20;
	logic sys_clk, srst, bus_wr, bus_rd, bus_bit_op, bus_rdata_valid, page_access;
	logic nvm_standby, nvm_busy_flag, row_mode_out, row_error, v;
	logic [7:0] bus_addr, bus_wdata, bus_rdata, r, d, run, last_len;
	logic [6:0] page_sel;
	logic [7:0] mem [128];
	logic [7:0] codes [8] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40, 8'h04, 8'h80};
	int bad_count = 0, check_count = 0, seed = 74683, cyc = 0;
	bed_core_model core (.sys_clk(sys_clk), .bus_rdata(bus_rdata),
		.bus_rdata_valid(bus_rdata_valid), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bit_op(bus_bit_op));
	bed_nvm_access #(.PROG_CYCLES(PROG)) uut (.sys_clk(sys_clk), .srst(srst),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_bit_op(bus_bit_op), .bus_rdata(bus_rdata), .bus_rdata_valid(bus_rdata_valid),
		.page_sel(page_sel), .page_access(page_access), .nvm_standby(nvm_standby),
		.nvm_busy_flag(nvm_busy_flag), .row_mode_out(row_mode_out), .row_error(row_error));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// busy length monitor plus hang guard; the run needs under 2000 cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		run <= nvm_busy_flag ? run + 8'h01 : 8'h00;
		if (!nvm_busy_flag && run != 8'h00) last_len <= run;
		if (cyc == 4000) begin
			bad_count++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask
	// a refused request must leave busy low
	task automatic idle_chk();
		repeat (8) begin
			tick();
			chk({7'b0, nvm_busy_flag}, 8'h00, "busy");
		end
	endtask
	// wait bounded for a programming cycle and measure its length
	task automatic prog_chk();
		int k = 0;
		do begin
			tick();
			k++;
		end while (nvm_busy_flag !== 1'b1 && k < 8);
		chk({7'b0, nvm_busy_flag}, 8'h01, "busy rise");
		do begin
			tick();
			k++;
		end while (nvm_busy_flag === 1'b1 && k < 100);
		tick();
		chk(last_len, 8'(PROG), "busy length");
	endtask
	task automatic nrd(input logic [6:0] i);
		core.rd({2'b00, i[5:0]}, r, v);
		chk({7'b0, v}, 8'h01, "read valid");
		chk(r, mem[i], "read data");
	endtask
	task automatic ctl(input logic [7:0] c);
		core.wr(8'hdf, c, 1'b0);
	endtask
	initial begin
		srst = 1'b1;
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		tick();
		core.rd(8'hdf, r, v);
		chk(r, 8'h00, "ctl reset");
		chk({1'b0, page_sel}, 8'h00, "bank unset");
		ctl(8'h01);
		core.wr(8'h05, 8'h5a, 1'b0);
		idle_chk();
		// every page code, the unused bits, then bit-op and read attempts
		foreach (codes[i]) begin
			core.wr(8'hcb, codes[i], 1'b0);
			tick();
			chk({1'b0, page_sel}, codes[i] & 8'h7b, "bank");
		end
		core.wr(8'hcb, 8'h01, 1'b1);
		core.rd(8'hcb, r, v);
		chk({v, page_sel}, 8'h00, "bank bit op");
		core.wr(8'hcb, 8'h01, 1'b0);
		ctl(8'h41);
		core.rd(8'h05, r, v);
		chk({v, 6'b0, nvm_standby}, 8'h01, "standby");
		core.wr(8'h05, 8'h5a, 1'b0);
		ctl(8'h00);
		core.wr(8'h05, 8'h5a, 1'b0);
		idle_chk();
		// byte mode fill of one row in each nvm page
		ctl(8'h01);
		for (int p = 1; p >= 0; p--) begin
			core.wr(8'hcb, 8'(p + 1), 1'b0);
			for (int i = 0; i < 8; i++) begin
				d = 8'($random(seed));
				mem[7'(p * 64 + 24 + i)] = d;
				core.wr(8'(24 + i), d, 1'b0);
				prog_chk();
			end
		end
		// requests during programming are refused, except the busy read
		core.wr(8'h18, ~mem[24], 1'b0);
		tick();
		tick();
		ctl(8'h40);
		core.rd(8'hdf, r, v);
		chk(r, 8'h02, "busy read");
		core.rd(8'h19, r, v);
		chk({7'b0, v}, 8'h00, "aborted read");
		mem[24] = ~mem[24];
		prog_chk();
		chk({7'b0, nvm_standby}, 8'h00, "ignored ctl");
		for (int i = 24; i < 32; i++) nrd(7'(i));
		// abandoned row leaves cells, fresh row mode clears the latches
		ctl(8'h05);
		tick();
		chk({7'b0, row_mode_out}, 8'h01, "row mode");
		// byte 1fh is left out of the next row, so a stale mark would show there
		core.wr(8'h1f, 8'h33, 1'b0);
		ctl(8'h01);
		idle_chk();
		ctl(8'h05);
		foreach (codes[i]) if (i < 3) begin
			d = 8'($random(seed));
			mem[7'(24 + i * i)] = d; // bytes 18h, 19h, 1ch
			core.wr(8'(24 + i * i), d, 1'b0);
		end
		ctl(8'h0d);
		prog_chk();
		chk({7'b0, row_mode_out}, 8'h00, "row end");
		for (int i = 24; i < 32; i++) nrd(7'(i));
		ctl(8'h09);
		idle_chk();
		ctl(8'h05);
		core.wr(8'h18, 8'h11, 1'b0);
		core.wr(8'h20, 8'h22, 1'b0);
		tick();
		chk({7'b0, row_error}, 8'h01, "row lock");
		ctl(8'h01);
		core.wr(8'hcb, 8'h02, 1'b0);
		for (int i = 24; i < 32; i++) nrd(7'(64 + i));
		results();
	end
endmodule
